// File: hdl/oaf_bank.sv
// result registers, clock dividers and two-wire register access
// Function
// - clock out divides by two to code power
// - second emitter result read-only at 2A
// - dark2 or third emitter result at 2B
// - first emitter result read-only at 2C
// - dark1 result read-only at 2D
// - 2E holds second emitter minus dark2
// - 2F holds first emitter minus dark1
// - results read zero after reset
// - 31 holds detach, short, external divider
// - clock pin driven only internal and enabled
// - external clock divided by table code
// - detach bit cuts sensor inputs from amp
// - short ties inputs to common mode powered-down
`timescale 1ns/1ps
`include "oaf_consts.svh"
module oaf_bank (
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire logic                scl,
    input  wire logic                sda_in,
    output logic                     sda_out,
    output logic                     sda_oe,
    input  wire logic                clk_pin_in,
    output logic                     clk_pin_out,
    output logic                     clk_pin_oe,
    input  wire logic                osc_mode,
    input  wire logic                amp_powered_down,
    input  wire logic                res_valid,
    input  wire oaf_pkg::oaf_phase_t res_sel,
    input  wire logic [23:0]         res_data,
    output logic                     timebase_tick,
    output logic                     sensor_input_detach,
    output logic                     sensor_input_short_cm
);
    import oaf_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic scl_m, scl_s, scl_q, sda_m, sda_s, sda_q, ck_m, ck_s, ck_q;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            {scl_m, scl_s, scl_q} <= 3'h7;
            {sda_m, sda_s, sda_q} <= 3'h7;
            {ck_m, ck_s, ck_q}    <= 3'h0;
        end
        else
        begin
            {scl_m, scl_s, scl_q} <= {scl, scl_m, scl_s};
            {sda_m, sda_s, sda_q} <= {sda_in, sda_m, sda_s};
            {ck_m, ck_s, ck_q}    <= {clk_pin_in, ck_m, ck_s};
        end
    end

    logic scl_rise, scl_fall, bus_start, bus_stop;
    assign scl_rise  = scl_s & ~scl_q;
    assign scl_fall  = ~scl_s & scl_q;
    assign bus_start = scl_s & scl_q & sda_q & ~sda_s;
    assign bus_stop  = scl_s & scl_q & ~sda_q & sda_s;

    ////////////////////////////////////////////////////////////////////////
    // result registers
    logic [23:0] led2, dark2, led1, dark1, net2, net1;
    logic [23:0] next_led2, next_dark2, next_led1, next_dark1;
    logic [23:0] next_net2, next_net1;

    always_comb
    begin
        next_led2  = led2;
        next_dark2 = dark2;
        next_led1  = led1;
        next_dark1 = dark1;
        if (res_valid)
        begin
            unique case (res_sel)
                ph_second_emitter: next_led2  = res_data;
                ph_dark2_or_third: next_dark2 = res_data;
                ph_first_emitter:  next_led1  = res_data;
                ph_dark1:          next_dark1 = res_data;
            endcase
        end
        // differences land in the same edge as their operands
        next_net2 = next_led2 - next_dark2;
        next_net1 = next_led1 - next_dark1;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            led2  <= `OAF_RES_RESET;
            dark2 <= `OAF_RES_RESET;
            led1  <= `OAF_RES_RESET;
            dark1 <= `OAF_RES_RESET;
            net2  <= `OAF_RES_RESET;
            net1  <= `OAF_RES_RESET;
        end
        else
        begin
            led2  <= next_led2;
            dark2 <= next_dark2;
            led1  <= next_led1;
            dark1 <= next_dark1;
            net2  <= next_net2;
            net1  <= next_net1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // configuration registers 29h and 31h
    logic        wr_en;
    logic [7:0]  wr_addr;
    logic [23:0] wr_data;
    logic        out_en, detach, short_en, next_out_en, next_detach;
    logic        next_short_en;
    logic [3:0]  out_code, next_out_code;
    logic [2:0]  ext_code, next_ext_code;

    always_comb
    begin
        next_out_en   = out_en;
        next_out_code = out_code;
        next_detach   = detach;
        next_short_en = short_en;
        next_ext_code = ext_code;
        if (wr_en && wr_addr == `OAF_RA_CLKOUT)
        begin
            next_out_en   = wr_data[`OAF_B_CLKOUT_EN];
            next_out_code = wr_data[`OAF_B_CLKDIV_MSB:`OAF_B_CLKDIV_LSB];
        end
        if (wr_en && wr_addr == `OAF_RA_INCFG)
        begin
            next_detach   = wr_data[`OAF_B_DETACH];
            next_short_en = wr_data[`OAF_B_SHORT];
            next_ext_code = wr_data[`OAF_B_EXTDIV_MSB:0];
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            out_en   <= 1'b0;
            out_code <= 4'h0;
            detach   <= 1'b0;
            short_en <= 1'b0;
            ext_code <= 3'h0;
        end
        else
        begin
            out_en   <= next_out_en;
            out_code <= next_out_code;
            detach   <= next_detach;
            short_en <= next_short_en;
            ext_code <= next_ext_code;
        end
    end

    // write-only detach bit reads back as zero
    function automatic logic [23:0] rd_val(input logic [7:0] a);
        logic [23:0] v;
        v = 24'h000000;
        unique case (a)
            `OAF_RA_LED2:  v = led2;
            `OAF_RA_DARK2: v = dark2;
            `OAF_RA_LED1:  v = led1;
            `OAF_RA_DARK1: v = dark1;
            `OAF_RA_NET2:  v = net2;
            `OAF_RA_NET1:  v = net1;
            `OAF_RA_CLKOUT:
            begin
                v[`OAF_B_CLKOUT_EN] = out_en;
                v[`OAF_B_CLKDIV_MSB:`OAF_B_CLKDIV_LSB] = out_code;
            end
            `OAF_RA_INCFG:
            begin
                v[`OAF_B_SHORT] = short_en;
                v[`OAF_B_EXTDIV_MSB:0] = ext_code;
            end
            default: v = 24'h000000;
        endcase
        return v;
    endfunction : rd_val

    ////////////////////////////////////////////////////////////////////////
    // two-wire slave
    oaf_i2c_st_t st, next_st, ack_next, next_ack_next;
    logic [2:0]  bitcnt, next_bitcnt;
    logic [1:0]  bytecnt, next_bytecnt;
    logic [7:0]  shift, next_shift, reg_addr, next_reg_addr, next_wr_addr;
    logic [15:0] wbuf, next_wbuf;
    logic [23:0] rsh, next_rsh, next_wr_data, rd_next, rd_cur;
    logic        ack_on, next_ack_on, acked, next_acked, next_sda_oe;
    logic        next_wr_en;
    logic [7:0]  in_byte;

    assign in_byte = {shift[6:0], sda_s};
    assign rd_next = rd_val(reg_addr + 8'h01);
    assign rd_cur  = rd_val(reg_addr);

    always_comb
    begin
        next_st = st; next_ack_next = ack_next; next_bitcnt = bitcnt;
        next_bytecnt = bytecnt; next_shift = shift; next_wbuf = wbuf;
        next_reg_addr = reg_addr; next_rsh = rsh; next_ack_on = ack_on;
        next_acked = acked; next_sda_oe = sda_oe; next_wr_en = 1'b0;
        next_wr_addr = wr_addr; next_wr_data = wr_data;
        if (bus_start)
        begin
            next_st = st_addr; next_bitcnt = 3'h0; next_sda_oe = 1'b0;
            next_ack_on = 1'b0;
        end
        else if (bus_stop)
        begin
            next_st = st_idle; next_sda_oe = 1'b0; next_ack_on = 1'b0;
        end
        else
        begin
            unique case (st)
                st_idle: next_sda_oe = 1'b0;
                st_addr, st_reg, st_wdata:
                    if (scl_rise)
                    begin
                        next_shift  = in_byte;
                        next_bitcnt = bitcnt + 3'h1;
                        if (bitcnt == `OAF_LAST_BIT)
                        begin
                            next_st = st_ack;
                            if (st == st_addr)
                            begin
                                if (in_byte[7:1] != `OAF_I2C_ADDR)
                                    next_st = st_idle;
                                next_ack_next = in_byte[0] ? st_rdata
                                                           : st_reg;
                            end
                            else if (st == st_reg)
                            begin
                                next_reg_addr = in_byte;
                                next_bytecnt  = 2'h0;
                                next_ack_next = st_wdata;
                            end
                            else if (bytecnt == `OAF_LAST_BYTE)
                            begin
                                // whole word commits at once, MSB first
                                next_wr_en    = 1'b1;
                                next_wr_addr  = reg_addr;
                                next_wr_data  = {wbuf, in_byte};
                                next_reg_addr = reg_addr + 8'h01;
                                next_bytecnt  = 2'h0;
                            end
                            else
                            begin
                                next_wbuf    = {wbuf[7:0], in_byte};
                                next_bytecnt = bytecnt + 2'h1;
                            end
                        end
                    end
                st_ack:
                    if (scl_fall && !ack_on)
                    begin
                        next_sda_oe = 1'b1;
                        next_ack_on = 1'b1;
                    end
                    else if (scl_fall)
                    begin
                        next_ack_on = 1'b0;
                        next_sda_oe = 1'b0;
                        next_st     = ack_next;
                        next_bitcnt = 3'h0;
                        if (ack_next == st_rdata)
                        begin
                            // snapshot keeps the three bytes coherent
                            next_rsh     = rd_cur;
                            next_sda_oe  = ~rd_cur[23];
                            next_bytecnt = 2'h0;
                        end
                    end
                st_rdata:
                    if (scl_fall)
                    begin
                        next_rsh    = {rsh[22:0], 1'b0};
                        next_bitcnt = bitcnt + 3'h1;
                        next_sda_oe = ~rsh[22];
                        if (bitcnt == `OAF_LAST_BIT)
                        begin
                            next_sda_oe = 1'b0;
                            next_st     = st_rack;
                        end
                    end
                st_rack:
                    if (scl_rise)
                        next_acked = ~sda_s;
                    else if (scl_fall && !acked)
                        next_st = st_idle;
                    else if (scl_fall)
                    begin
                        next_st = st_rdata;
                        if (bytecnt == `OAF_LAST_BYTE)
                        begin
                            next_reg_addr = reg_addr + 8'h01;
                            next_rsh      = rd_next;
                            next_sda_oe   = ~rd_next[23];
                            next_bytecnt  = 2'h0;
                        end
                        else
                        begin
                            next_sda_oe  = ~rsh[23];
                            next_bytecnt = bytecnt + 2'h1;
                        end
                    end
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st <= st_idle; ack_next <= st_idle; bitcnt <= 3'h0;
            bytecnt <= 2'h0; shift <= 8'h00; wbuf <= 16'h0000;
            reg_addr <= 8'h00; rsh <= 24'h000000; ack_on <= 1'b0;
            acked <= 1'b0; sda_oe <= 1'b0; wr_en <= 1'b0;
            wr_addr <= 8'h00; wr_data <= 24'h000000; sda_out <= 1'b0;
        end
        else
        begin
            st <= next_st; ack_next <= next_ack_next; bitcnt <= next_bitcnt;
            bytecnt <= next_bytecnt; shift <= next_shift; wbuf <= next_wbuf;
            reg_addr <= next_reg_addr; rsh <= next_rsh; ack_on <= next_ack_on;
            acked <= next_acked; sda_oe <= next_sda_oe; wr_en <= next_wr_en;
            wr_addr <= next_wr_addr; wr_data <= next_wr_data;
            sda_out <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // oscillator half-period ticks and the two dividers
    logic [3:0] hcnt, next_hcnt;
    logic       half_tick, osc_ph, next_osc_ph;
    logic       drive, next_clk_out, next_tick, next_short_cm;
    logic [7:0] ext_ratio;

    assign half_tick = (hcnt == 4'(`OAF_OSC_HALF_CYC - 1));
    assign drive = osc_mode && out_en &&
                   out_code <= `OAF_CLKOUT_MAX_CODE;

    always_comb
    begin
        unique case (ext_code)
            3'h0:    ext_ratio = `OAF_EXT_R0;
            3'h1:    ext_ratio = `OAF_EXT_R1;
            3'h3:    ext_ratio = `OAF_EXT_R3;
            3'h4:    ext_ratio = `OAF_EXT_R4;
            3'h5:    ext_ratio = `OAF_EXT_R5;
            3'h6:    ext_ratio = `OAF_EXT_R6;
            default: ext_ratio = `OAF_EXT_STOP;
        endcase
    end

    oaf_div_if od ();
    oaf_div_if xd ();
    assign od.tick  = half_tick;
    assign od.run   = drive;
    assign od.ratio = 8'h01 << out_code[2:0];
    assign xd.tick  = ck_s & ~ck_q;
    assign xd.run   = ~osc_mode;
    assign xd.ratio = ext_ratio;

    oaf_div u_out_div (.clk(clk), .rst(rst), .d(od));
    oaf_div u_ext_div (.clk(clk), .rst(rst), .d(xd));

    always_comb
    begin
        next_hcnt     = half_tick ? 4'h0 : hcnt + 4'h1;
        next_osc_ph   = half_tick ? ~osc_ph : osc_ph;
        next_clk_out  = drive & od.level;
        next_tick     = osc_mode ? (half_tick & osc_ph) : xd.pulse;
        next_short_cm = short_en & amp_powered_down;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            hcnt <= 4'h0; osc_ph <= 1'b0; clk_pin_out <= 1'b0;
            clk_pin_oe <= 1'b0; timebase_tick <= 1'b0;
            sensor_input_detach <= 1'b0; sensor_input_short_cm <= 1'b0;
        end
        else
        begin
            hcnt <= next_hcnt; osc_ph <= next_osc_ph;
            clk_pin_out <= next_clk_out;
            clk_pin_oe <= drive;
            timebase_tick <= next_tick;
            sensor_input_detach <= detach;
            sensor_input_short_cm <= next_short_cm;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    logic [9:0] tgl_cnt;
    logic       tgl_ok;
    logic [3:0] prev_code;
    logic       tgl;
    logic       prev_pin;
    assign tgl = clk_pin_oe && (clk_pin_out != prev_pin);
    always_ff @(posedge clk)
    begin
        prev_pin  <= clk_pin_out;
        prev_code <= out_code;
        tgl_cnt   <= tgl ? 10'h000 : tgl_cnt + 10'h001;
        tgl_ok    <= rst || !clk_pin_oe || out_code != prev_code ? 1'b0
                   : tgl ? 1'b1 : tgl_ok;
    end

    sequence s_cfg_write;
        wr_en && wr_addr == `OAF_RA_INCFG;
    endsequence
    sequence s_cfg_seen;
        ##2 sensor_input_detach == $past(wr_data[`OAF_B_DETACH], 2);
    endsequence

    a_clkout_period: assert property (tgl && tgl_ok |->
        tgl_cnt == 10'((`OAF_OSC_HALF_CYC << prev_code) - 1))
        else $error("clock out half period wrong");
    a_led2_store: assert property (
        res_valid && res_sel == ph_second_emitter |=> led2 == $past(res_data))
        else $error("second emitter result not stored");
    a_dark2_store: assert property (
        res_valid && res_sel == ph_dark2_or_third |=> dark2 == $past(res_data))
        else $error("dark2 result not stored");
    a_led1_store: assert property (
        res_valid && res_sel == ph_first_emitter |=> led1 == $past(res_data))
        else $error("first emitter result not stored");
    a_dark1_store: assert property (
        res_valid && res_sel == ph_dark1 |=> dark1 == $past(res_data))
        else $error("dark1 result not stored");
    a_net2_diff: assert property (net2 == led2 - dark2)
        else $error("second net differs from operands");
    a_net1_diff: assert property (net1 == led1 - dark1)
        else $error("first net differs from operands");
    a_result_reset: assert property ($past(rst) |->
        led2 == 24'h0 && dark2 == 24'h0 && led1 == 24'h0 &&
        dark1 == 24'h0 && net2 == 24'h0 && net1 == 24'h0)
        else $error("result not zero after reset");
    a_cfg_detach: assert property (s_cfg_write |-> s_cfg_seen)
        else $error("detach bit not taken from write");
    a_clkout_gate: assert property (!osc_mode || !out_en |=>
        !clk_pin_oe ##1 !clk_pin_out)
        else $error("clock pin driven outside internal mode");
    a_short_gate: assert property (
        !short_en || !amp_powered_down |=> !sensor_input_short_cm)
        else $error("inputs shorted while not allowed");

endmodule : oaf_bank

// File: hdl/oaf_consts.svh
// register offsets, field positions and timing counts of the result bank
`ifndef OAF_CONSTS_SVH
`define OAF_CONSTS_SVH

`define OAF_DATA_W          24
`define OAF_RES_RESET       24'h000000
`define OAF_RA_CLKOUT       8'h29
`define OAF_RA_LED2         8'h2A
`define OAF_RA_DARK2        8'h2B
`define OAF_RA_LED1         8'h2C
`define OAF_RA_DARK1        8'h2D
`define OAF_RA_NET2         8'h2E
`define OAF_RA_NET1         8'h2F
`define OAF_RA_INCFG        8'h31

`define OAF_B_CLKOUT_EN     9
`define OAF_B_CLKDIV_MSB    4
`define OAF_B_CLKDIV_LSB    1
`define OAF_B_DETACH        10
`define OAF_B_SHORT         5
`define OAF_B_EXTDIV_MSB    2
`define OAF_CLKOUT_MAX_CODE 4'h7

// 7-bit address on the two-wire bus; arbitrary value
`define OAF_I2C_ADDR        7'h5A
`define OAF_LAST_BIT        3'h7
`define OAF_LAST_BYTE       2'h2

`define OAF_CLK_PERIOD_NS   25
`define OAF_OSC_PERIOD_NS   250
`define OAF_OSC_HALF_CYC    ((`OAF_OSC_PERIOD_NS / 2 + `OAF_CLK_PERIOD_NS - 1) / `OAF_CLK_PERIOD_NS)

`define OAF_EXT_R0          8'h02
`define OAF_EXT_R1          8'h08
`define OAF_EXT_R3          8'h0C
`define OAF_EXT_R4          8'h04
`define OAF_EXT_R5          8'h01
`define OAF_EXT_R6          8'h06
`define OAF_EXT_STOP        8'h00

`endif

// File: hdl/oaf_pkg.sv
// types shared by the result bank modules
package oaf_pkg;

    typedef enum logic [1:0] {
        ph_second_emitter,
        ph_dark2_or_third,
        ph_first_emitter,
        ph_dark1
    } oaf_phase_t;

    typedef enum logic [2:0] {
        st_idle,
        st_addr,
        st_reg,
        st_wdata,
        st_ack,
        st_rdata,
        st_rack
    } oaf_i2c_st_t;

endpackage : oaf_pkg

// File: hdl/oaf_div_if.sv
// tick divider hookup between the bank and its divider instances
`timescale 1ns/1ps
interface oaf_div_if;
    logic       tick;
    logic       run;
    logic [7:0] ratio;
    logic       pulse;
    logic       level;

    modport ctl (output tick, output run, output ratio,
                 input pulse, input level);
    modport div (input tick, input run, input ratio,
                 output pulse, output level);
endinterface : oaf_div_if

// File: hdl/oaf_div.sv
// divides a tick stream by a ratio, giving a pulse and a toggling level
`timescale 1ns/1ps
`include "oaf_consts.svh"
module oaf_div (
    input  wire logic clk,
    input  wire logic rst,
    oaf_div_if.div    d
);
    logic [7:0] cnt;
    logic [7:0] next_cnt;
    logic       pulse;
    logic       next_pulse;
    logic       level;
    logic       next_level;

    always_comb
    begin
        next_cnt   = cnt;
        next_pulse = 1'b0;
        next_level = level;
        // ratio zero marks a reserved code: hold still rather than guess
        if (!d.run || d.ratio == `OAF_EXT_STOP)
        begin
            next_cnt   = 8'h00;
            next_level = 1'b0;
        end
        else if (d.tick)
        begin
            if (cnt >= d.ratio - 8'h01)
            begin
                next_cnt   = 8'h00;
                next_pulse = 1'b1;
                next_level = ~level;
            end
            else
            begin
                next_cnt = cnt + 8'h01;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            cnt   <= 8'h00;
            pulse <= 1'b0;
            level <= 1'b0;
        end
        else
        begin
            cnt   <= next_cnt;
            pulse <= next_pulse;
            level <= next_level;
        end
    end

    assign d.pulse = pulse;
    assign d.level = level;

endmodule : oaf_div

// File: tb/oaf_host.sv
// two-wire host model for the result bank
`timescale 1ns/1ps
module oaf_host (
    input  wire logic clk,
    input  wire logic sda,
    output logic      scl  = 1'b1,
    output logic      pull = 1'b0
);
    // msb first; the ninth bit is the acknowledge slot
    task automatic byte_io(input logic [8:0] w, output logic [8:0] r);
        for (int i = 8; i >= 0; i--)
        begin
            // data moves well clear of the scl fall, never a false stop
            repeat (2) @(negedge clk);
            pull = !w[i];
            repeat (8) @(negedge clk);
            scl = 1'b1;
            repeat (8) @(negedge clk);
            r[i] = sda;
            scl = 1'b0;
        end
    endtask : byte_io
    task automatic cond(input logic s);
        repeat (2) @(negedge clk);
        pull = !s;
        repeat (8) @(negedge clk);
        scl = 1'b1;
        repeat (8) @(negedge clk);
        pull = s;
        repeat (8) @(negedge clk);
        scl = !s;
    endtask : cond
    // words come back raw; the caller judges the 2E difference
    task automatic xfer(input logic rd, input logic [7:0] a,
                        input logic [23:0] w, output logic [23:0] r);
        logic [8:0] t;
        cond(1'b1);
        byte_io({8'hB4, 1'b1}, t);
        byte_io({a, 1'b1}, t);
        if (rd)
        begin
            cond(1'b1);
            byte_io({8'hB5, 1'b1}, t);
        end
        for (int k = 2; k >= 0; k--)
        begin
            byte_io({rd ? 8'hFF : w[k*8+:8], !rd || k == 0}, t);
            r[k*8+:8] = t[8:1];
        end
        cond(1'b0);
    endtask : xfer
endmodule : oaf_host

// File: tb/tb.sv
// self-checking bench for the result bank
`timescale 1ns/1ps
module tb;
    import oaf_pkg::*;
    logic        clk, scl, pull, sda, tick, detach, short_cm, pin_out;
    logic        pin_oe, sda_oe, rst = 1'b1, osc = 1'b0, amp_pd = 1'b0;
    logic        valid = 1'b0, ext_clk = 1'b0, ext_run = 1'b0;
    oaf_phase_t  sel = ph_second_emitter;
    logic [23:0] data = 24'h000000, v;
    logic        sda_lvl;
    int          fail_count, comparisons, n;
    assign sda = !(pull || sda_oe);
    oaf_bank uut (.clk(clk), .rst(rst), .scl(scl), .sda_in(sda),
        .sda_out(sda_lvl), .sda_oe(sda_oe), .clk_pin_in(ext_clk),
        .clk_pin_out(pin_out), .clk_pin_oe(pin_oe), .osc_mode(osc),
        .amp_powered_down(amp_pd), .res_valid(valid), .res_sel(sel),
        .res_data(data), .timebase_tick(tick),
        .sensor_input_detach(detach), .sensor_input_short_cm(short_cm));
    oaf_host host (.clk(clk), .sda(sda), .scl(scl), .pull(pull));
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // external clock pin, eight system cycles a period, parked low
    always
    begin
        repeat (4) @(negedge clk);
        ext_clk <= ext_run & ~ext_clk;
    end
    ////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : finish_test
    task automatic chk(input string nm, input logic [23:0] e,
                       input logic [23:0] g);
        comparisons++;
        if (g !== e)
        begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // cycles (or pin rises, for the tick) between two rising edges
    task automatic gap(input logic use_tick, output int cnt);
        logic p, q, s;
        int   e;
        p = 1'b1;
        q = ext_clk;
        e = 0;
        cnt = 0;
        for (int i = 0; i < 6000 && e < 2; i++)
        begin
            @(negedge clk);
            s = use_tick ? tick : pin_out;
            if (e == 1 && (!use_tick || (ext_clk && !q)))
                cnt++;
            if (s === 1'b1 && p === 1'b0)
                e++;
            p = s;
            q = ext_clk;
        end
        if (e < 2)
        begin
            fail_count++;
            $display("[FAIL] edge wait expected 2 seen %0d", e);
            finish_test();
        end
    endtask : gap
    task automatic t_reset();
        // 30 is unmapped and reads zero as well
        for (int a = 8'h2A; a <= 8'h31; a++)
        begin
            host.xfer(1'b1, 8'(a), 24'h000000, v);
            chk("reset value", 24'h000000, v);
        end
    endtask : t_reset
    task automatic t_results();
        logic [23:0] x [6];
        x = '{24'h000123, 24'h000200, 24'h400000, 24'hF00000,
              24'hFFFF23, 24'h500000};
        for (int i = 0; i < 4; i++)
        begin
            valid = 1'b1;
            sel = oaf_phase_t'(i);
            data = x[i];
            @(negedge clk);
        end
        valid = 1'b0;
        for (int i = 0; i < 6; i++)
        begin
            host.xfer(1'b1, 8'(8'h2A + i), 24'h000000, v);
            chk("result", x[i], v);
        end
    endtask : t_results
    task automatic t_config();
        host.xfer(1'b0, 8'h31, 24'h000425, v);
        host.xfer(1'b1, 8'h31, 24'h000000, v);
        chk("config readback", 24'h000025, v);
        chk("detach", 24'h000001, 24'(detach));
        chk("sda out level", 24'h000000, 24'(sda_lvl));
        chk("short powered", 24'h000000, 24'(short_cm));
        amp_pd = 1'b1;
        repeat (2) @(negedge clk);
        chk("short powered down", 24'h000001, 24'(short_cm));
        amp_pd = 1'b0;
    endtask : t_config
    task automatic t_clkout();
        osc = 1'b1;
        for (int c = 0; c < 8; c++)
        begin
            host.xfer(1'b0, 8'h29, 24'(12'h200 | (c << 1)), v);
            gap(1'b0, n);
            chk("clkout period", 24'(10 << c), 24'(n));
        end
        chk("clkout driven", 24'h000001, 24'(pin_oe));
        osc = 1'b0;
        repeat (2) @(negedge clk);
        chk("clkout ext mode", 24'h000000, 24'(pin_oe));
        // reserved divider codes must leave the pin undriven
        osc = 1'b1;
        host.xfer(1'b0, 8'h29, 24'h000210, v);
        chk("clkout code 8", 24'h000000, 24'(pin_oe));
        osc = 1'b0;
    endtask : t_clkout
    task automatic t_ext();
        int cd [6] = '{0, 1, 3, 4, 5, 6};
        int rt [6] = '{2, 8, 12, 4, 1, 6};
        ext_run = 1'b1;
        for (int i = 0; i < 6; i++)
        begin
            host.xfer(1'b0, 8'h31, 24'(cd[i]), v);
            // first gap may straddle the ratio change
            gap(1'b1, n);
            gap(1'b1, n);
            chk("ext ratio", 24'(rt[i]), 24'(n));
        end
        // a reserved code stops the timebase altogether
        host.xfer(1'b0, 8'h31, 24'h000002, v);
        n = 0;
        repeat (200) @(negedge clk) n += tick;
        chk("ext reserved tick", 24'h000000, 24'(n));
        ext_run = 1'b0;
    endtask : t_ext
    initial
    begin
        repeat (4) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        t_reset();
        t_results();
        t_config();
        t_clkout();
        t_ext();
        finish_test();
    end
endmodule : tb
